/* File: common/cas_defs.vh */
`ifndef CAS_DEFS_VH
`define CAS_DEFS_VH

// ============================================================
// register byte offsets
`define CAS_OFF_CTRL     8'h00
`define CAS_OFF_STATUS   8'h04
`define CAS_OFF_ACC      8'h08
`define CAS_OFF_FADDR    8'h0C
`define CAS_OFF_FDATA    8'h10
`define CAS_OFF_WDOG     8'h14
`define CAS_OFF_WAKE     8'h18

// ============================================================
// instruction word fields (CTRL register)
`define CAS_OP_MSB       3
`define CAS_OP_LSB       0
`define CAS_DEST_BIT     4
`define CAS_FA_MSB       14
`define CAS_FA_LSB       8
`define CAS_LIT_MSB      23
`define CAS_LIT_LSB      16

// ============================================================
// operation codes
`define CAS_OP_ROT_RIGHT 4'h0
`define CAS_OP_LIT_SUB   4'h1
`define CAS_OP_FILE_SUB  4'h2
`define CAS_OP_XOR_FILE  4'h3
`define CAS_OP_XOR_LIT   4'h4
`define CAS_OP_SWAP      4'h5
`define CAS_OP_SLEEP     4'h6

// ============================================================
// status register bit positions
`define CAS_ST_CARRY     0
`define CAS_ST_NIBBLE    1
`define CAS_ST_ZERO      2
`define CAS_ST_PWD_N     3
`define CAS_ST_EXP_N     4
`define CAS_ST_ASLEEP    5
`define CAS_ST_BUSY      6

// ============================================================
// watchdog readback fields
`define CAS_WD_CNT_LSB   0
`define CAS_WD_PRE_LSB   8

// ============================================================
// reset and clear values
`define CAS_RST_FLAG     1'h0
`define CAS_RST_FLAG_N   1'h1
`define CAS_RST_BYTE     8'h00
`define CAS_RST_WORD     32'h0000_0000
`define CAS_WDOG_CLEAR   8'h00

`endif

/* File: src/cas_file_mem.v */
`timescale 1ns/1ps
// ============================================================
// file register storage, registered read
module cas_file_mem #(
	parameter AW = 7,
	parameter DW = 8
) (
	// clock
	input  wire          clk_sys_i,
	// write port
	input  wire          we_i,
	input  wire [AW-1:0] waddr_i,
	input  wire [DW-1:0] wdata_i,
	// read port
	input  wire [AW-1:0] raddr_i,
	output reg  [DW-1:0] rdata_o
);

	reg [DW-1:0] mem_r [0:(1<<AW)-1];

	// no reset on the array; contents are undefined until written
	always @(posedge clk_sys_i) begin
		if (we_i) begin
			mem_r[waddr_i] <= wdata_i;
		end
		rdata_o <= mem_r[raddr_i];
	end

endmodule

/* File: src/cas_alu_top.v */
// Overview of operation
// RULE_01: sleep clears the watchdog counter and its prescaler to zero.
// RULE_02: sleep clears powerdown flag, sets expiry flag, leaves other flags.
// RULE_03: after sleep the core halts in low-power state until woken.
// RULE_04: rotate file right through carry; old bit 0 becomes carry.
// RULE_05: 7-bit file address; destination select 0 accumulator, 1 file.
// RULE_06: literal minus acc into acc; updates carry, nibble and zero flags.
// RULE_07: carry set when acc <= literal; nibble flag same on low nibbles.
// RULE_08: file minus acc to chosen destination; updates carry, nibble, zero.
// RULE_09: carry set when acc <= file; nibble flag same on low nibbles.
// RULE_10: acc xor file to selected destination; only zero flag changes.
// RULE_11: acc xor literal into accumulator; only zero flag changes.
// RULE_12: swap file nibbles to selected destination; no flags change.
// RULE_13: zero flag set exactly when the 8-bit result is zero.
// RULE_14: each operation completes write-back and flags in one cycle.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "cas_defs.vh"

module cas_alu_top #(
	parameter ADDR_W = 8,
	parameter FA_W   = 7,
	parameter WDOG_W = 8,
	parameter PRE_W  = 8
) (
	// clock and reset
	input  wire              clk_sys_i,
	input  wire              rst_n_i,
	// apb slave
	input  wire              psel_i,
	input  wire              penable_i,
	input  wire              pwrite_i,
	input  wire [ADDR_W-1:0] paddr_i,
	input  wire [31:0]       pwdata_i,
	output reg  [31:0]       prdata_o,
	output reg               pready_o,
	output reg               pslverr_o,
	// core state
	output reg               sleep_o
);

	// ============================================================
	// reset synchroniser
	reg rst_meta_r;
	reg rst_sync_r;
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// ============================================================
	// sequencer states
	localparam [1:0] S_IDLE  = 2'h0;
	localparam [1:0] S_FETCH = 2'h1;
	localparam [1:0] S_EXEC  = 2'h2;
	reg [1:0]      state_r;
	reg            idle_d_r;
	reg [3:0]      ins_op_r;
	reg            ins_dest_r;
	reg [FA_W-1:0] ins_fa_r;
	reg [7:0]      ins_lit_r;
	// architectural state
	reg [7:0]        acc_r;
	reg [FA_W-1:0]   faddr_r;
	reg              carry_r;
	reg              nib_r;
	reg              zero_r;
	reg              pwd_n_r;
	reg              exp_n_r;
	reg [WDOG_W-1:0] wdog_cnt_r;
	reg [PRE_W-1:0]  wdog_pre_r;

	// ============================================================
	// apb decode
	wire       acc_phase = psel_i & penable_i;
	wire       done      = acc_phase & pready_o;
	wire       wr_done   = done & pwrite_i;
	wire       can_ans   = (state_r == S_IDLE) & idle_d_r;
	wire [3:0] wr_op     = pwdata_i[`CAS_OP_MSB:`CAS_OP_LSB];
	wire       op_known  = (wr_op <= `CAS_OP_SLEEP);
	wire       is_ctrl   = (paddr_i == `CAS_OFF_CTRL);
	// instructions are refused while asleep or when the code is unknown
	wire       ctrl_bad  = is_ctrl & pwrite_i & (sleep_o | ~op_known);
	wire       issue     = wr_done & is_ctrl & ~sleep_o & op_known;
	reg [31:0] rd_mux;
	reg        addr_err;
	wire [7:0] mem_rdata;

	always @* begin
		rd_mux   = `CAS_RST_WORD;
		addr_err = 1'b0;
		case (paddr_i)
		`CAS_OFF_CTRL, `CAS_OFF_WAKE: begin
			rd_mux = `CAS_RST_WORD;
		end
		`CAS_OFF_STATUS: begin
			rd_mux[`CAS_ST_CARRY]  = carry_r;
			rd_mux[`CAS_ST_NIBBLE] = nib_r;
			rd_mux[`CAS_ST_ZERO]   = zero_r;
			rd_mux[`CAS_ST_PWD_N]  = pwd_n_r;
			rd_mux[`CAS_ST_EXP_N]  = exp_n_r;
			rd_mux[`CAS_ST_ASLEEP] = sleep_o;
			rd_mux[`CAS_ST_BUSY]   = (state_r != S_IDLE);
		end
		`CAS_OFF_ACC: begin
			rd_mux[7:0] = acc_r;
		end
		`CAS_OFF_FADDR: begin
			rd_mux[FA_W-1:0] = faddr_r;
		end
		`CAS_OFF_FDATA: begin
			rd_mux[7:0] = mem_rdata;
		end
		`CAS_OFF_WDOG: begin
			rd_mux[`CAS_WD_CNT_LSB +: WDOG_W] = wdog_cnt_r;
			rd_mux[`CAS_WD_PRE_LSB +: PRE_W]  = wdog_pre_r;
		end
		default: begin
			addr_err = 1'b1;
		end
		endcase
	end

	// registered answer; one wait state at least, more while busy
	always @(posedge clk_sys_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= `CAS_RST_WORD;
		end else if (acc_phase & ~pready_o & can_ans) begin
			pready_o  <= 1'b1;
			pslverr_o <= addr_err | ctrl_bad;
			prdata_o  <= pwrite_i ? `CAS_RST_WORD : rd_mux;
		end else begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

	// ============================================================
	// datapath
	wire [7:0] fval = mem_rdata;
	wire [7:0] aval = ins_op_r == `CAS_OP_LIT_SUB ? ins_lit_r : fval;
	wire [8:0] diff = {1'b0, aval} - {1'b0, acc_r};
	reg [7:0] res;
	reg       c_nxt;
	reg       hc_nxt;
	reg       upd_c;
	reg       upd_hc;
	reg       upd_z;
	reg       to_file;
	reg       to_acc;
	always @* begin
		res     = `CAS_RST_BYTE;
		c_nxt   = carry_r;
		hc_nxt  = nib_r;
		upd_c   = 1'b0;
		upd_hc  = 1'b0;
		upd_z   = 1'b0;
		to_file = 1'b0;
		to_acc  = 1'b0;
		case (ins_op_r)
		`CAS_OP_ROT_RIGHT: begin
			res     = {carry_r, fval[7:1]}; // RULE_04
			c_nxt   = fval[0]; // RULE_04
			upd_c   = 1'b1;
			to_file = ins_dest_r; // RULE_05
			to_acc  = ~ins_dest_r;
		end
		`CAS_OP_LIT_SUB: begin
			res    = diff[7:0]; // RULE_06
			c_nxt  = ~diff[8]; // RULE_07
			hc_nxt = (acc_r[3:0] <= ins_lit_r[3:0]); // RULE_07
			upd_c  = 1'b1;
			upd_hc = 1'b1;
			upd_z  = 1'b1;
			to_acc = 1'b1; // RULE_06
		end
		`CAS_OP_FILE_SUB: begin
			res     = diff[7:0]; // RULE_08
			c_nxt   = ~diff[8]; // RULE_09
			hc_nxt  = (acc_r[3:0] <= fval[3:0]); // RULE_09
			upd_c   = 1'b1;
			upd_hc  = 1'b1;
			upd_z   = 1'b1;
			to_file = ins_dest_r; // RULE_08
			to_acc  = ~ins_dest_r;
		end
		`CAS_OP_XOR_FILE: begin
			res     = acc_r ^ fval; // RULE_10
			upd_z   = 1'b1;
			to_file = ins_dest_r; // RULE_10
			to_acc  = ~ins_dest_r;
		end
		`CAS_OP_XOR_LIT: begin
			res    = acc_r ^ ins_lit_r; // RULE_11
			upd_z  = 1'b1;
			to_acc = 1'b1; // RULE_11
		end
		`CAS_OP_SWAP: begin
			res     = {fval[3:0], fval[7:4]}; // RULE_12
			to_file = ins_dest_r; // RULE_12
			to_acc  = ~ins_dest_r;
		end
		default: begin
			res = `CAS_RST_BYTE;
		end
		endcase
	end
	wire exec    = (state_r == S_EXEC);
	wire ex_wr_f = exec & to_file;
	wire ex_slp  = exec & (ins_op_r == `CAS_OP_SLEEP);

	// ============================================================
	// sequencer: fetch operand, then execute in a single cycle
	always @(posedge clk_sys_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			state_r    <= S_IDLE;
			idle_d_r   <= 1'b0;
			ins_op_r   <= `CAS_OP_ROT_RIGHT;
			ins_dest_r <= 1'b0;
			ins_fa_r   <= {FA_W{1'b0}};
			ins_lit_r  <= `CAS_RST_BYTE;
		end else begin
			idle_d_r <= (state_r == S_IDLE);
			case (state_r)
			S_IDLE: begin
				if (issue) begin
					state_r    <= S_FETCH;
					ins_op_r   <= wr_op;
					ins_dest_r <= pwdata_i[`CAS_DEST_BIT]; // RULE_05
					ins_fa_r   <= pwdata_i[`CAS_FA_MSB:`CAS_FA_LSB];
					ins_lit_r  <= pwdata_i[`CAS_LIT_MSB:`CAS_LIT_LSB];
				end
			end
			S_FETCH: begin
				state_r <= S_EXEC;
			end
			S_EXEC: begin
				state_r <= S_IDLE; // RULE_14
			end
			default: begin
				state_r <= S_IDLE;
			end
			endcase
		end
	end

	// ============================================================
	// accumulator, flags, sleep
	wire st_wr = wr_done & (paddr_i == `CAS_OFF_STATUS);
	always @(posedge clk_sys_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			acc_r   <= `CAS_RST_BYTE;
			faddr_r <= {FA_W{1'b0}};
			carry_r <= `CAS_RST_FLAG;
			nib_r   <= `CAS_RST_FLAG;
			zero_r  <= `CAS_RST_FLAG;
			pwd_n_r <= `CAS_RST_FLAG_N;
			exp_n_r <= `CAS_RST_FLAG_N;
			sleep_o <= 1'b0;
		end else begin
			if (exec & to_acc) begin
				acc_r <= res; // RULE_05
			end else if (wr_done & (paddr_i == `CAS_OFF_ACC)) begin
				acc_r <= pwdata_i[7:0];
			end
			if (wr_done & (paddr_i == `CAS_OFF_FADDR)) begin
				faddr_r <= pwdata_i[FA_W-1:0];
			end
			if (exec & upd_c) begin
				carry_r <= c_nxt;
			end else if (st_wr) begin
				carry_r <= pwdata_i[`CAS_ST_CARRY];
			end
			if (exec & upd_hc) begin
				nib_r <= hc_nxt;
			end else if (st_wr) begin
				nib_r <= pwdata_i[`CAS_ST_NIBBLE];
			end
			if (exec & upd_z) begin
				zero_r <= (res == `CAS_RST_BYTE); // RULE_13
			end else if (st_wr) begin
				zero_r <= pwdata_i[`CAS_ST_ZERO];
			end
			if (ex_slp) begin
				pwd_n_r <= 1'b0; // RULE_02
				exp_n_r <= 1'b1; // RULE_02
				sleep_o <= 1'b1; // RULE_03
			end else if (wr_done & (paddr_i == `CAS_OFF_WAKE)) begin
				sleep_o <= 1'b0;
			end
		end
	end

	// ============================================================
	// watchdog: free running, cleared by sleep
	always @(posedge clk_sys_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			wdog_cnt_r <= {WDOG_W{1'b0}};
			wdog_pre_r <= {PRE_W{1'b0}};
		end else if (ex_slp) begin
			wdog_cnt_r <= `CAS_WDOG_CLEAR; // RULE_01
			wdog_pre_r <= {PRE_W{1'b0}}; // RULE_01
		end else begin
			wdog_pre_r <= wdog_pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
			if (&wdog_pre_r) begin
				wdog_cnt_r <= wdog_cnt_r + {{(WDOG_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// ============================================================
	// file register storage
	wire            fd_wr  = wr_done & (paddr_i == `CAS_OFF_FDATA);
	wire [FA_W-1:0] m_rad  = (state_r == S_IDLE) ? faddr_r : ins_fa_r;
	wire [FA_W-1:0] m_wad  = ex_wr_f ? ins_fa_r : faddr_r;
	wire [7:0]      m_wdat = ex_wr_f ? res : pwdata_i[7:0];
	cas_file_mem #(
		.AW (FA_W),
		.DW (8)
	) u_mem (
		.clk_sys_i (clk_sys_i),
		.we_i      (ex_wr_f | fd_wr),
		.waddr_i   (m_wad),
		.wdata_i   (m_wdat),
		.raddr_i   (m_rad),
		.rdata_o   (mem_rdata)
	);

endmodule

/* File: bench/cas_alu_properties.sv */
`timescale 1ns/1ps
// ====================
// port checks
module cas_alu_chk #(
	parameter ADDR_W = 8
) (
	input wire              clk_sys_i,
	input wire              rst_n_i,
	input wire              psel_i,
	input wire              penable_i,
	input wire              pwrite_i,
	input wire [ADDR_W-1:0] paddr_i,
	input wire [31:0]       pwdata_i,
	input wire [31:0]       prdata_o,
	input wire              pready_o,
	input wire              pslverr_o,
	input wire              sleep_o
);
	wire take = psel_i & penable_i & pready_o;
	wire ctrl_wr = take & pwrite_i & (paddr_i == 8'h00);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	chk_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready too long");
	chk_ready_access: assert property (pready_o |-> psel_i && penable_i)
		else $error("ready outside access");
	chk_err_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	chk_sleep_enter: assert property (
		ctrl_wr && pwdata_i[3:0] == 4'h6 && !pslverr_o |-> ##[1:4] sleep_o)
		else $error("sleep not entered");
	chk_sleep_hold: assert property (
		sleep_o && !(take && pwrite_i && paddr_i == 8'h18) |=> sleep_o)
		else $error("sleep left without wake");
	chk_asleep_refuse: assert property (ctrl_wr && sleep_o |-> pslverr_o)
		else $error("command taken while asleep");
	chk_bad_op: assert property (ctrl_wr && pwdata_i[3:0] > 4'h6 |-> pslverr_o)
		else $error("bad opcode accepted");
	chk_unmapped_err: assert property (take && paddr_i > 8'h18 |-> pslverr_o)
		else $error("unmapped address accepted");
	chk_err_data: assert property (
		pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
		else $error("error read data not zero");
endmodule
bind cas_alu_top cas_alu_chk #(.ADDR_W(ADDR_W)) u_chk (
	.clk_sys_i (clk_sys_i),
	.rst_n_i   (rst_n_i),
	.psel_i    (psel_i),
	.penable_i (penable_i),
	.pwrite_i  (pwrite_i),
	.paddr_i   (paddr_i),
	.pwdata_i  (pwdata_i),
	.prdata_o  (prdata_o),
	.pready_o  (pready_o),
	.pslverr_o (pslverr_o),
	.sleep_o   (sleep_o)
);

/* File: bench/cas_alu_top_bench.sv */
`timescale 1ns/1ps
module cas_alu_top_bench;
	logic        clk_sys_i, rst_n_i, psel_i, penable_i, pwrite_i;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, rdat;
	logic        pready_o, pslverr_o, sleep_o, err;
	int          failures = 0, cmp_count = 0, i;
	cas_alu_top u_dut (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.psel_i    (psel_i),
		.penable_i (penable_i),
		.pwrite_i  (pwrite_i),
		.paddr_i   (paddr_i),
		.pwdata_i  (pwdata_i),
		.prdata_o  (prdata_o),
		.pready_o  (pready_o),
		.pslverr_o (pslverr_o),
		.sleep_o   (sleep_o)
	);
	// ====================
	// bus and compare helpers
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string n, input [31:0] e, input [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", n, e, g);
			failures++;
		end
	endtask
	// one idle edge after release so back-to-back calls never collide
	task xfer(input [7:0] a, input w, input [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		@(posedge clk_sys_i);
		while (pready_o !== 1'b1) @(posedge clk_sys_i);
		rdat = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task rdchk(input string n, input [7:0] a, input [31:0] e);
		xfer(a, 1'b0, 32'h0);
		chk(n, e, rdat);
	endtask
	task op(input [3:0] c, input dst, input [6:0] fa, input [7:0] lit);
		xfer(8'h00, 1'b1, {8'h00, lit, 1'b0, fa, 3'h0, dst, c});
		for (i = 0; i < 20; i++) begin
			xfer(8'h04, 1'b0, 32'h0);
			if (rdat[6] === 1'b0) break;
		end
		chk("busy", 32'h0, i);
	endtask
	// ====================
	// scenarios
	task t_rot;
		xfer(8'h0C, 1'b1, 32'h7F);
		xfer(8'h10, 1'b1, 32'h81);
		xfer(8'h04, 1'b1, 32'h05);
		op(4'h0, 1'b1, 7'h7F, 8'h00);
		rdchk("file", 8'h10, 32'hC0);
		rdchk("stat", 8'h04, 32'h1D);
		op(4'h0, 1'b0, 7'h7F, 8'h00);
		rdchk("acc", 8'h08, 32'hE0);
		rdchk("file", 8'h10, 32'hC0);
		rdchk("stat", 8'h04, 32'h1C);
		$display("rotate done");
	endtask
	// packed as acc, literal, result, status
	task sub1(input [31:0] v);
		xfer(8'h08, 1'b1, {24'h0, v[31:24]});
		op(4'h1, 1'b0, 7'h00, v[23:16]);
		rdchk("acc", 8'h08, {24'h0, v[15:8]});
		rdchk("stat", 8'h04, {24'h0, v[7:0]});
	endtask
	task t_sub;
		sub1(32'h0505_001F);
		sub1(32'h0605_FF18);
		sub1(32'h1F20_0119);
		sub1(32'h00FF_FF1B);
		xfer(8'h0C, 1'b1, 32'h03);
		xfer(8'h10, 1'b1, 32'h10);
		xfer(8'h08, 1'b1, 32'h01);
		op(4'h2, 1'b1, 7'h03, 8'h00);
		rdchk("file", 8'h10, 32'h0F);
		rdchk("stat", 8'h04, 32'h19);
		xfer(8'h08, 1'b1, 32'h0F);
		op(4'h2, 1'b0, 7'h03, 8'h00);
		rdchk("acc", 8'h08, 32'h00);
		rdchk("stat", 8'h04, 32'h1F);
		$display("subtract done");
	endtask
	task t_xor;
		xfer(8'h10, 1'b1, 32'h5A);
		xfer(8'h08, 1'b1, 32'h5A);
		xfer(8'h04, 1'b1, 32'h03);
		op(4'h3, 1'b0, 7'h03, 8'h00);
		rdchk("acc", 8'h08, 32'h00);
		rdchk("stat", 8'h04, 32'h1F);
		op(4'h4, 1'b0, 7'h00, 8'hFF);
		rdchk("acc", 8'h08, 32'hFF);
		rdchk("stat", 8'h04, 32'h1B);
		op(4'h3, 1'b1, 7'h03, 8'h00);
		rdchk("file", 8'h10, 32'hA5);
		xfer(8'h04, 1'b1, 32'h07);
		op(4'h5, 1'b0, 7'h03, 8'h00);
		rdchk("acc", 8'h08, 32'h5A);
		op(4'h5, 1'b1, 7'h03, 8'h00);
		rdchk("file", 8'h10, 32'h5A);
		rdchk("stat", 8'h04, 32'h1F);
		$display("xor and swap done");
	endtask
	task t_sleep;
		xfer(8'h00, 1'b1, 32'h06);
		for (i = 0; i < 10 && sleep_o !== 1'b1; i++) @(posedge clk_sys_i);
		chk("sleep", 32'h1, {31'h0, sleep_o});
		rdchk("stat", 8'h04, 32'h37);
		xfer(8'h14, 1'b0, 32'h0);
		chk("wdog", 32'h0, {24'h0, rdat[7:0]});
		chk("prescale", 32'h1, {31'h0, rdat[15:8] < 8'h40});
		xfer(8'h00, 1'b1, 32'h04);
		chk("err", 32'h1, {31'h0, err});
		xfer(8'h18, 1'b1, 32'h01);
		for (i = 0; i < 10 && sleep_o !== 1'b0; i++) @(posedge clk_sys_i);
		chk("sleep", 32'h0, {31'h0, sleep_o});
		rdchk("stat", 8'h04, 32'h17);
		$display("sleep done");
	endtask
	task t_err;
		xfer(8'h40, 1'b0, 32'h0);
		chk("err", 32'h1, {31'h0, err});
		chk("rdat", 32'h0, rdat);
		xfer(8'h00, 1'b1, 32'h07);
		chk("err", 32'h1, {31'h0, err});
		rdchk("faddr", 8'h0C, 32'h03);
		rdchk("ctrl", 8'h00, 32'h0);
		rdchk("wake", 8'h18, 32'h0);
		chk("err", 32'h0, {31'h0, err});
		$display("errors done");
	endtask
	// ====================
	// run
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		rst_n_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		rdchk("stat", 8'h04, 32'h18);
		t_rot;
		t_sub;
		t_xor;
		t_sleep;
		t_err;
		stop_test;
	end
	initial begin
		#20000;
		failures++;
		stop_test;
	end
endmodule
